/* hw/ptt_regs.svh */
`ifndef PTT_REGS_SVH
`define PTT_REGS_SVH
// register byte offsets
`define PTT_CTRL_OFS 8'h00
`define PTT_CFG_OFS 8'h04
`define PTT_CNT_OFS 8'h08
// control register fields
`define PTT_RUN_BIT 1
`define PTT_IE_BIT 2
`define PTT_ACK_BIT 3
`define PTT_RATE_LSB 4
`define PTT_RATE_MSB 6
`define PTT_PEND_BIT 7
// configuration register fields
`define PTT_EXT_BIT 0
`define PTT_KEEP_BIT 1
// reset values
`define PTT_CTRL_RST 8'h00
`define PTT_CFG_RST 8'h00
// number of divider stages
`define PTT_STAGES 15
`endif

/* hw/ptt_pkg.sv */
package ptt_pkg;
  typedef logic [2:0] ptt_rate_t;
  typedef logic [3:0] ptt_tap_t;
  typedef logic [15:0] ptt_div_t;

  // stage index whose rise marks the selected tap
  function automatic ptt_tap_t ptt_tap_index(input ptt_rate_t r);
    case (r)
      3'h0: return 4'hE;
      3'h1: return 4'hC;
      3'h2: return 4'hA;
      3'h3: return 4'h6;
      3'h4: return 4'h5;
      3'h5: return 4'h4;
      3'h6: return 4'h3;
      default: return 4'h2;
    endcase
  endfunction

  // full divider value in source clocks
  function automatic ptt_div_t ptt_divider(input ptt_rate_t r);
    return ptt_div_t'(16'h0002 << ptt_tap_index(r));
  endfunction
endpackage

/* hw/ptt_div_if.sv */
`timescale 1ns/100ps
`include "ptt_regs.svh"
interface ptt_div_if;
  logic run;
  logic adv;
  ptt_pkg::ptt_rate_t rate;
  logic [`PTT_STAGES-1:0] count;
  logic tick;
  modport ctl (output run, output adv, output rate,
               input count, input tick);
  modport div (input run, input adv, input rate,
               output count, output tick);
endinterface

/* hw/ptt_divider.sv */
`timescale 1ns/100ps
`include "ptt_regs.svh"
module ptt_divider (
  input wire logic clk_i,
  input wire logic rst_i,
  ptt_div_if.div dv
);
  logic tap_q;
  logic tap_now;
  logic [15:0] since;
  logic first;

  // inverted tap: falls when the tap stage rises
  always_comb begin
    tap_now = ~dv.count[ptt_pkg::ptt_tap_index(dv.rate)];
  end

  // binary chain, held at zero while stopped
  always_ff @(posedge clk_i) begin
    if (rst_i || !dv.run) begin
      dv.count <= '0;
    end else if (dv.adv) begin
      dv.count <= dv.count + 15'h0001;
    end
  end

  // last tap level for fall detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tap_q <= 1'b1;
    end else begin
      tap_q <= tap_now;
    end
  end

  // one pulse per tap fall
  assign dv.tick = tap_q & ~tap_now;

  // helper: source clocks since enable or last tick
  always_ff @(posedge clk_i) begin
    if (rst_i || !dv.run) begin
      since <= 16'h0000;
      first <= 1'b1;
    end else if (dv.tick) begin
      since <= {15'h0000, dv.adv};
      first <= 1'b0;
    end else if (dv.adv) begin
      since <= since + 16'h0001;
    end
  end

  hold_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !dv.run |=> dv.count == '0)
    else $error("chain not held at zero");

  chain_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    dv.run && $past(dv.run) && $past(dv.adv)
      |-> dv.count == $past(dv.count) + 15'h0001)
    else $error("chain did not advance");

  first_half_a: assert property (@(posedge clk_i) disable iff (rst_i)
    dv.tick && first
      |-> since == (ptt_pkg::ptt_divider(dv.rate) >> 1))
    else $error("first tick not at half period");

  full_period_a: assert property (@(posedge clk_i) disable iff (rst_i)
    dv.tick && !first
      |-> since == ptt_pkg::ptt_divider(dv.rate))
    else $error("tick period wrong");
endmodule

/* hw/ptt_timebase.sv */
// What this block does
// - stopped chain held at all zeros
// - chain advances once run is set
// - tap overflow sets the pending flag
// - pending and enabled raises interrupt request
// - acknowledge one clears, else flag stays
// - first tick half period, then full
// - external clock used whenever it is on
// - counts in stop if oscillator kept
// - rate select picks one of eight dividers
// - period is divider times source period
// - fifteen stages, eight selectable taps
// - reset clears run and interrupt enable
// - acknowledge reads zero, zero write ignored
// - keeps counting and flagging in wait
`timescale 1ns/100ps
`include "ptt_regs.svh"
module ptt_timebase (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic external_clock_i,
  input wire logic internal_clock_i,
  input wire logic stop_mode_i,
  input wire logic wait_mode_i,
  output logic tick_irq_o
);
  ptt_div_if dv ();

  // software state
  logic tick_run_enable;
  logic tick_irq_enable;
  ptt_pkg::ptt_rate_t tick_rate_select;
  logic tick_pending_flag;
  logic external_clock_on;
  logic osc_keep_in_stop;

  // source clock synchronisers
  logic ext_s1;
  logic ext_s2;
  logic ext_s3;
  logic int_s1;
  logic int_s2;
  logic int_s3;
  logic ext_rise;
  logic int_rise;
  logic src_rise;
  logic clock_alive;

  // bus decode
  logic bus_req;
  logic bus_blocked;
  logic wr_take;
  logic wr_ctrl;
  logic wr_cfg;
  logic ack_clr;
  logic next_flag;
  logic [31:0] rd_word;

  // two flops before the edge detectors
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
    end else begin
      ext_s1 <= external_clock_i;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_s1 <= 1'b0;
      int_s2 <= 1'b0;
      int_s3 <= 1'b0;
    end else begin
      int_s1 <= internal_clock_i;
      int_s2 <= int_s1;
      int_s3 <= int_s2;
    end
  end

  // rising edges of the source clocks as enables
  assign ext_rise = ext_s2 & ~ext_s3;
  assign int_rise = int_s2 & ~int_s3;

  // external source whenever it is switched on
  assign src_rise = external_clock_on ? ext_rise : int_rise;

  // in stop the source only runs when kept alive; wait never gates
  assign clock_alive = !stop_mode_i || osc_keep_in_stop;

  // hand the divider its controls
  assign dv.run = tick_run_enable;
  assign dv.adv = src_rise & clock_alive;
  assign dv.rate = tick_rate_select;

  ptt_divider u_div (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .dv (dv.div)
  );

  // classic wishbone request and its one-cycle answer
  assign bus_req = wb_cyc_i & wb_stb_i;

  // registers are out of reach in wait and stop
  assign bus_blocked = wait_mode_i | stop_mode_i;

  // writes land on the edge that samples ack
  assign wr_take = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0]
                   & ~bus_blocked;
  assign wr_ctrl = wr_take && (wb_adr_i[7:2] == `PTT_CTRL_OFS >> 2);
  assign wr_cfg = wr_take && (wb_adr_i[7:2] == `PTT_CFG_OFS >> 2);

  // only a written one acknowledges
  assign ack_clr = wr_ctrl & wb_dat_i[`PTT_ACK_BIT];

  // ack toggles high for one cycle per request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
    end
  end

  // read mux, unmapped and blocked read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (!bus_blocked) begin
      case (wb_adr_i[7:2])
        `PTT_CTRL_OFS >> 2: begin
          rd_word[`PTT_PEND_BIT] = tick_pending_flag;
          rd_word[`PTT_RATE_MSB:`PTT_RATE_LSB] = tick_rate_select;
          rd_word[`PTT_IE_BIT] = tick_irq_enable;
          rd_word[`PTT_RUN_BIT] = tick_run_enable;
        end
        `PTT_CFG_OFS >> 2: begin
          rd_word[`PTT_EXT_BIT] = external_clock_on;
          rd_word[`PTT_KEEP_BIT] = osc_keep_in_stop;
        end
        `PTT_CNT_OFS >> 2: begin
          rd_word[`PTT_STAGES-1:0] = dv.count;
        end
        default: begin
          rd_word = 32'h0000_0000;
        end
      endcase
    end
  end

  // read data captured with the rising ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_ack_o) begin
      wb_dat_o <= rd_word;
    end
  end

  // control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_run_enable <= 1'(`PTT_CTRL_RST >> `PTT_RUN_BIT);
      tick_irq_enable <= 1'(`PTT_CTRL_RST >> `PTT_IE_BIT);
      tick_rate_select <= 3'h0;
    end else if (wr_ctrl) begin
      tick_run_enable <= wb_dat_i[`PTT_RUN_BIT];
      tick_irq_enable <= wb_dat_i[`PTT_IE_BIT];
      // software keeps the rate steady while running
      tick_rate_select <= wb_dat_i[`PTT_RATE_MSB:`PTT_RATE_LSB];
    end
  end

  // configuration register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      external_clock_on <= 1'b0;
      osc_keep_in_stop <= 1'b0;
    end else if (wr_cfg) begin
      external_clock_on <= wb_dat_i[`PTT_EXT_BIT];
      osc_keep_in_stop <= wb_dat_i[`PTT_KEEP_BIT];
    end
  end

  // sticky flag: a tick beats a same-cycle acknowledge
  assign next_flag = dv.tick | (tick_pending_flag & ~ack_clr);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_pending_flag <= 1'b0;
    end else begin
      tick_pending_flag <= next_flag;
    end
  end

  // request follows flag and enable, one cycle later
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_irq_o <= 1'b0;
    end else begin
      tick_irq_o <= tick_pending_flag & tick_irq_enable;
    end
  end

  irq_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 tick_irq_o == $past(tick_pending_flag & tick_irq_enable))
    else $error("interrupt request does not follow flag and enable");

  flag_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tick_pending_flag && !ack_clr |=> tick_pending_flag)
    else $error("pending flag dropped without acknowledge");

  ack_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_clr && !dv.tick |=> !tick_pending_flag)
    else $error("acknowledge did not clear flag");

  set_wins_a: assert property (@(posedge clk_i) disable iff (rst_i)
    dv.tick |=> tick_pending_flag ##1 tick_irq_o == $past(tick_irq_enable))
    else $error("tick lost or request missing");

  zero_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctrl && !wb_dat_i[`PTT_ACK_BIT] && tick_pending_flag
      |=> tick_pending_flag)
    else $error("zero acknowledge changed the flag");

  ack_reads_zero_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    wb_ack_o |-> !wb_dat_o[`PTT_ACK_BIT])
    else $error("acknowledge bit read back as one");

  reset_clears_a: assert property (@(posedge clk_i)
    $past(rst_i) |-> !tick_run_enable && !tick_irq_enable)
    else $error("reset left run or interrupt enable set");

  source_pick_a: assert property (@(posedge clk_i) disable iff (rst_i)
    clock_alive && (external_clock_on ? ext_rise : int_rise)
      |-> dv.adv)
    else $error("selected source edge not used");

  other_src_a: assert property (@(posedge clk_i) disable iff (rst_i)
    external_clock_on && !ext_rise |-> !dv.adv)
    else $error("internal edge used while external is on");

  stop_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    stop_mode_i && !osc_keep_in_stop |-> !dv.adv)
    else $error("chain advanced in stop without oscillator");

  wait_runs_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wait_mode_i && !stop_mode_i && src_rise |-> dv.adv)
    else $error("chain stalled in wait");

  bus_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not a single cycle pulse");
endmodule

/* tb/ptt_cpu_model.sv */
`timescale 1ns/100ps
module ptt_cpu_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic irq_i,
  output logic [31:0] irq_count_o
);
  logic irq_q;
  // counts each new request latched by the cpu side
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
      irq_count_o <= 32'h0;
    end else begin
      irq_q <= irq_i;
      if (irq_i && !irq_q) irq_count_o <= irq_count_o + 32'h1;
    end
  end
endmodule

/* tb/ptt_timebase_tb.sv */
`timescale 1ns/100ps
`include "ptt_regs.svh"
module ptt_timebase_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic external_clock_i = 1'b0;
  logic internal_clock_i = 1'b0;
  logic stop_mode_i = 1'b0;
  logic wait_mode_i = 1'b0;
  logic tick_irq_o;
  logic [31:0] irq_seen;
  logic [31:0] rdv;
  logic [2:0] sdiv = 3'h0;
  ptt_pkg::ptt_rate_t rate;
  int n_errors = 0;
  int check_count = 0;
  int cyc_n = 0;
  int n_irq = 0;
  int t0, t1, t2, h, src, div;
  int divs [8] = '{32'h8000, 32'h2000, 32'h800, 32'h80,
                   32'h40, 32'h20, 32'h10, 32'h8};

  always #12.5 clk_i = ~clk_i;

  // free cycle stamp and the two source clocks (4 and 8 clocks)
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    sdiv <= sdiv + 3'h1;
    external_clock_i <= sdiv[1];
    internal_clock_i <= sdiv[2];
  end

  ptt_timebase i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .external_clock_i(external_clock_i),
    .internal_clock_i(internal_clock_i), .stop_mode_i(stop_mode_i),
    .wait_mode_i(wait_mode_i), .tick_irq_o(tick_irq_o)
  );

  ptt_cpu_model i_cpu (
    .clk_i(clk_i), .rst_i(rst_i), .irq_i(tick_irq_o),
    .irq_count_o(irq_seen)
  );

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task results;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // one classic wishbone cycle, held until ack is sampled
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] q);
    int i;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    // ack is sampled on the rising edge; data taken at that same edge
    for (i = 0; i < 100; i++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    if (i == 100) begin
      n_errors++;
      results();
    end else begin
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask

  // waits for a fresh rise of the request, stamps its cycle
  task wait_irq(output int t);
    int i;
    logic p;
    p = 1'b1;
    for (i = 0; i < 20000; i++) begin
      @(negedge clk_i);
      if (p === 1'b0 && tick_irq_o === 1'b1) break;
      p = tick_irq_o;
    end
    if (i == 20000) begin
      n_errors++;
      results();
    end else begin
      t = cyc_n;
      n_irq++;
    end
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`PTT_CTRL_OFS, rdv); chk(rdv, 32'h0);
    rd(`PTT_CFG_OFS, rdv); chk(rdv, 32'h0);
    rd(`PTT_CNT_OFS, rdv); chk(rdv, 32'h0);
    rd(8'h0C, rdv); chk(rdv, 32'h0);
    $display("test reset done");
    // rates 7..2 on the external source, then rate 7 on internal
    for (int k = 0; k < 7; k++) begin
      rate = (k == 6) ? 3'h7 : 3'(7 - k);
      src = (k == 6) ? 8 : 4;
      div = divs[rate];
      h = div * src / 2;
      wr(`PTT_CFG_OFS, (k == 6) ? 32'h0 : 32'h1);
      wr(`PTT_CTRL_OFS, 32'({rate, 4'hE}));
      t0 = cyc_n;
      rd(`PTT_CTRL_OFS, rdv); chk(rdv, 32'({rate, 4'h6}));
      wait_irq(t1);
      // source phase at enable may shift the first tick by one source period
      chk(32'(t1 - t0 >= h - src && t1 - t0 <= h + src + 10), 32'h1);
      wr(`PTT_CTRL_OFS, 32'({rate, 4'hE}));
      wait_irq(t2);
      chk(32'(t2 - t1), 32'(div * src));
      wr(`PTT_CTRL_OFS, 32'({rate, 4'h8}));
    end
    $display("test rates done");
    wr(`PTT_CFG_OFS, 32'h3);
    wr(`PTT_CTRL_OFS, 32'h7E);
    wait_irq(t1);
    wr(`PTT_CTRL_OFS, 32'h7E);
    stop_mode_i <= 1'b1;
    wait_irq(t2);
    chk(32'(t2 - t1), 32'h20);
    @(posedge clk_i);
    stop_mode_i <= 1'b0;
    wr(`PTT_CTRL_OFS, 32'h7E);
    wait_mode_i <= 1'b1;
    wait_irq(t1);
    chk(32'(t1 - t2), 32'h20);
    rd(`PTT_CTRL_OFS, rdv); chk(rdv, 32'h0);
    @(posedge clk_i);
    wait_mode_i <= 1'b0;
    $display("test modes done");
    rd(`PTT_CTRL_OFS, rdv); chk(rdv, 32'hF6);
    wr(`PTT_CTRL_OFS, 32'h70);
    rd(`PTT_CTRL_OFS, rdv); chk(rdv, 32'hF0);
    rd(`PTT_CNT_OFS, rdv); chk(rdv, 32'h0);
    chk(32'(tick_irq_o), 32'h0);
    wr(`PTT_CTRL_OFS, 32'h78);
    rd(`PTT_CTRL_OFS, rdv); chk(rdv, 32'h70);
    chk(irq_seen, 32'(n_irq));
    $display("test flags done");
    results();
  end
endmodule
